// ---- oic_pkg.sv ----
// Package: constants and carrier types for the online interval counter
`default_nettype none

package oic_pkg;

    // ==========================================
    // Widths and reset values
    localparam int unsigned LINE_W      = 5;
    localparam int unsigned NLINES      = 32;
    localparam int unsigned CNT_W       = 16;
    localparam int unsigned OUTPAT_W    = 8;
    localparam logic [6:0]  RPT_MIN     = 7'h01;
    localparam logic [6:0]  RPT_MAX     = 7'h63;
    localparam logic [6:0]  RPT_RST     = 7'h01;
    localparam logic [15:0] BASE_RST    = 16'h0028;
    localparam logic [15:0] EXT1_RST    = 16'h003c;
    localparam logic [15:0] EXT2_RST    = 16'h000f;
    localparam logic [15:0] STORE_RST   = 16'h0000;

    // ==========================================
    // Configuration set, committed as a whole
    typedef struct packed {
        logic [LINE_W-1:0]   on_line;
        logic                on_state;
        logic                out_en;
        logic [OUTPAT_W-1:0] out_pat;
        logic                full_on;
        logic                full_off;
        logic [15:0]         base_cycles;
        logic [15:0]         ext1_bases;
        logic [15:0]         ext2_bases;
        logic [15:0]         base_store;
        logic [15:0]         ext1_store;
        logic [15:0]         ext2_store;
        logic [6:0]          report_num;
    } oic_cfg_t;

    // ==========================================
    // Results
    typedef struct packed {
        logic             base_bit;
        logic             base_valid;
        logic [CNT_W-1:0] ext1_total;
        logic             ext1_valid;
        logic [CNT_W-1:0] ext2_total;
        logic             ext2_valid;
    } oic_res_t;

endpackage

`default_nettype wire

// ---- oic_counter.sv ----
// Online interval counter: pattern match, debounce, per-interval totals
//
// Overview of operation
// [RULE1] Per base interval, check pattern, count matches
// [RULE2] Extended total equals qualifying base interval count
// [RULE3] Base interval result is exactly 0 or 1
// [RULE4] Condition is line number plus required state
// [RULE5] Output pattern follows current online condition
// [RULE6] Reconfigured pattern leaves old output lines driven
// [RULE7] Full-on Yes: whole interval needed; default No
// [RULE8] Full-off No: whole interval unmet needed; default No
// [RULE9] Debounced changes only at interval boundary
// [RULE10] Full-on Yes debounces on; No immediate
// [RULE11] Full-off Yes immediate off; No debounced
// [RULE12] Extended intervals are base-interval multiples (config side)
// [RULE13] Each total has own interval and storage length; the store lengths are only held in the config, no logic uses them
// [RULE14] Edits apply only on commit; abandon discards
// [RULE15] Report number limited to 01..99
// [RULE16] Extended totals restart at interval start
`timescale 1ns/1ps
`default_nettype none

module oic_counter
    import oic_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_sys_in,
    input  wire logic                sys_rst_in,
    // Digital input lines
    input  wire logic [NLINES-1:0]   dig_in,
    // Configuration edit and commit
    input  wire oic_cfg_t            cfg_edit_in,
    input  wire logic                cfg_commit_in,
    input  wire logic                cfg_abandon_in,
    // Results and output lines
    output oic_cfg_t                 cfg_active_out,
    output logic                     cfg_reject_out,
    output logic                     online_out,
    output logic [OUTPAT_W-1:0]      out_lines_out,
    output oic_res_t                 res_out
);

    // ==========================================
    // Committed configuration
    oic_cfg_t cfg_q;
    logic     reject_q;
    wire      rpt_ok   = cfg_edit_in.report_num >= RPT_MIN && cfg_edit_in.report_num <= RPT_MAX; // [RULE15]
    wire      ints_ok  = cfg_edit_in.base_cycles != 16'h0000 && cfg_edit_in.ext1_bases != 16'h0000
                         && cfg_edit_in.ext2_bases != 16'h0000;
    wire      cfg_take = cfg_commit_in && !cfg_abandon_in && rpt_ok && ints_ok; // [RULE14]

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            cfg_q    <= '{on_line: '0, on_state: 1'b1, out_en: 1'b0, out_pat: '0,
                          full_on: 1'b0, full_off: 1'b0, // [RULE7] [RULE8]
                          base_cycles: BASE_RST, ext1_bases: EXT1_RST, ext2_bases: EXT2_RST,
                          base_store: STORE_RST, ext1_store: STORE_RST, ext2_store: STORE_RST,
                          report_num: RPT_RST};
            reject_q <= 1'b0;
        end
        else
        begin
            if (cfg_take)
                cfg_q <= cfg_edit_in; // [RULE13] [RULE14]
            reject_q <= cfg_commit_in && !cfg_take;
        end
    end

    // ==========================================
    // Raw condition and interval tracking
    // Limitation: one watched line only; several conditions need another channel
    wire raw_on = dig_in[cfg_q.on_line] == cfg_q.on_state; // [RULE4]

    logic [15:0]      base_cnt_q;
    logic [15:0]      ext1_cnt_q;
    logic [15:0]      ext2_cnt_q;
    logic             all_on_q;
    logic             all_off_q;
    logic             online_q;
    logic [CNT_W-1:0] tot1_q;
    logic [CNT_W-1:0] tot2_q;
    oic_res_t         res_q;
    logic [OUTPAT_W-1:0] lines_q;

    // Compare with >= so that an interval shortened mid-count still ends at once
    wire base_end = base_cnt_q >= cfg_q.base_cycles - 16'h0001;
    wire ext1_end = base_end && ext1_cnt_q >= cfg_q.ext1_bases - 16'h0001;
    wire ext2_end = base_end && ext2_cnt_q >= cfg_q.ext2_bases - 16'h0001;
    // Whole-interval history including this cycle's sample
    wire held_on  = all_on_q && raw_on;
    wire held_off = all_off_q && !raw_on;

    // Debounce: instantaneous edges act now, debounced ones wait for the boundary
    wire rise_now = !online_q && raw_on && !cfg_q.full_on;      // [RULE10]
    wire fall_now = online_q && !raw_on && cfg_q.full_off;      // [RULE11]
    wire rise_bnd = !online_q && base_end && held_on;           // [RULE7] [RULE9]
    wire fall_bnd = online_q && base_end && held_off;           // [RULE8] [RULE9]
    wire online_d = (rise_now || rise_bnd) ? 1'b1 :
                    (fall_now || fall_bnd) ? 1'b0 : online_q;

    // Interval result: online at any time in the interval, whether rises are instant or debounced
    logic seen_q;
    wire  base_bit = online_d || seen_q || (raw_on && !cfg_q.full_on); // [RULE1] [RULE3]

    wire [CNT_W-1:0] tot1_n = tot1_q + {{(CNT_W-1){1'b0}}, base_bit};
    wire [CNT_W-1:0] tot2_n = tot2_q + {{(CNT_W-1){1'b0}}, base_bit};

    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            base_cnt_q <= 16'h0000;
            ext1_cnt_q <= 16'h0000;
            ext2_cnt_q <= 16'h0000;
            all_on_q   <= 1'b1;
            all_off_q  <= 1'b1;
            online_q   <= 1'b0;
            seen_q     <= 1'b0;
            tot1_q     <= '0;
            tot2_q     <= '0;
        end
        else
        begin
            online_q   <= online_d;
            base_cnt_q <= base_end ? 16'h0000 : base_cnt_q + 16'h0001;
            all_on_q   <= base_end ? 1'b1 : held_on;
            all_off_q  <= base_end ? 1'b1 : held_off;
            seen_q     <= base_end ? 1'b0 : (seen_q || online_d);
            if (base_end)
            begin
                ext1_cnt_q <= ext1_end ? 16'h0000 : ext1_cnt_q + 16'h0001;
                ext2_cnt_q <= ext2_end ? 16'h0000 : ext2_cnt_q + 16'h0001;
                tot1_q     <= ext1_end ? '0 : tot1_n; // [RULE16]
                tot2_q     <= ext2_end ? '0 : tot2_n; // [RULE16]
            end
        end
    end

    // ==========================================
    // Result and output registers
    always_ff @(posedge clk_sys_in)
    begin
        if (sys_rst_in)
        begin
            res_q   <= '0;
            lines_q <= '0;
        end
        else
        begin
            res_q.base_valid <= base_end;
            res_q.ext1_valid <= ext1_end;
            res_q.ext2_valid <= ext2_end;
            if (base_end)
                res_q.base_bit <= base_bit; // [RULE3]
            if (ext1_end)
                res_q.ext1_total <= tot1_n; // [RULE2]
            if (ext2_end)
                res_q.ext2_total <= tot2_n; // [RULE2]
            // Only lines in the current pattern are touched, so lines dropped
            // from an old pattern keep their last level
            if (cfg_q.out_en)
                lines_q <= online_d ? (lines_q | cfg_q.out_pat)
                                    : (lines_q & ~cfg_q.out_pat); // [RULE5] [RULE6]
        end
    end

    assign cfg_active_out = cfg_q;
    assign cfg_reject_out = reject_q;
    assign online_out     = online_q;
    assign out_lines_out  = lines_q;
    assign res_out        = res_q;

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (sys_rst_in);

    a_instant_rise: assert property (!online_q && raw_on && !cfg_q.full_on |=> online_q) // [RULE10]
        else $error("instant rise missed");
    a_instant_fall: assert property (online_q && !raw_on && cfg_q.full_off |=> !online_q) // [RULE11]
        else $error("instant fall missed");
    a_deb_rise: assert property (!online_q && cfg_q.full_on && !base_end |=> !online_q) // [RULE9]
        else $error("debounced rise off boundary");
    a_deb_fall: assert property (online_q && !cfg_q.full_off && !base_end |=> online_q) // [RULE9]
        else $error("debounced fall off boundary");
    a_full_on: assert property (!online_q && cfg_q.full_on && base_end && !all_on_q |=> !online_q) // [RULE7]
        else $error("partial interval counted online");
    a_full_off: assert property (online_q && !cfg_q.full_off && base_end && !all_off_q |=> online_q) // [RULE8]
        else $error("partial interval counted offline");
    a_ext_restart: assert property (base_end && ext1_end |=> tot1_q == '0) // [RULE16]
        else $error("total did not restart");
    a_ext_report: assert property (ext1_end |=> res_q.ext1_total == $past(tot1_n) && res_q.ext1_valid) // [RULE2]
        else $error("extended total wrong");
    a_cfg_hold: assert property (!cfg_take |=> $stable(cfg_q)) // [RULE14]
        else $error("config changed without commit");
    a_rpt_range: assert property (cfg_q.report_num >= RPT_MIN && cfg_q.report_num <= RPT_MAX) // [RULE15]
        else $error("report number out of range");
    a_out_follow: assert property (cfg_q.out_en |=> ((out_lines_out & $past(cfg_q.out_pat)) // [RULE5]
                                   == (online_q ? $past(cfg_q.out_pat) : '0)))
        else $error("output lines do not follow");
    a_ext2_report: assert property (ext2_end |=> res_q.ext2_total == $past(tot2_n) && res_q.ext2_valid) // [RULE2]
        else $error("second extended total wrong");
    a_ext2_restart: assert property (ext2_end |=> tot2_q == '0) // [RULE16]
        else $error("second total did not restart");
    a_bad_commit: assert property (cfg_commit_in && !rpt_ok |=> cfg_reject_out && $stable(cfg_q)) // [RULE15]
        else $error("bad report number not refused");
    a_base_online: assert property (base_end && online_d |=> res_q.base_bit && res_q.base_valid) // [RULE1] [RULE3]
        else $error("online interval not counted");

    // ==========================================
    // Coverage of the main scenarios
    c_ext1_end: cover property (ext1_end && tot1_n != '0);
    c_rise_now: cover property (rise_now);
    c_rise_bnd: cover property (rise_bnd);
    c_fall_bnd: cover property (fall_bnd);
    c_commit:   cover property (cfg_take);

endmodule

`default_nettype wire

// ---- oic_line_model.sv ----
// Model of the digital input lines that feed the online interval counter
`timescale 1ns/1ps
`default_nettype none

module oic_line_model
    import oic_pkg::*;
(
    // Clock
    input  wire logic              clk_in,
    // Commanded level of the watched line
    input  wire logic [LINE_W-1:0] line_in,
    input  wire logic              level_in,
    // Input lines seen by the counter
    output logic [NLINES-1:0]      dig_out
);
    // ==========================================
    // Unwatched lines toggle every cycle so a wrong line decode shows up
    logic [NLINES-1:0] noise_q = 32'h5a5a_c3c3;
    always @(negedge clk_in)
    begin
        noise_q <= ~noise_q;
    end
    assign dig_out = (noise_q & ~(32'h1 << line_in)) | ({31'h0, level_in} << line_in);
endmodule

`default_nettype wire

// ---- online_interval_counter_bench.sv ----
// Self-checking bench for the online interval counter
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
    $display("mismatch %s exp %0h got %0h", nm, e, g); end end

module online_interval_counter_bench;
    import oic_pkg::*;
    logic              clk_sys_in = 1'b0;
    logic              sys_rst_in = 1'b1;
    logic              commit     = 1'b0;
    logic              abandon    = 1'b0;
    logic              lvl        = 1'b0;
    logic [LINE_W-1:0] ln         = 5'h03;
    logic [NLINES-1:0] din;
    oic_cfg_t          cfg        = '0;
    oic_cfg_t          act;
    logic              rej;
    logic              onl;
    logic [OUTPAT_W-1:0] ol;
    oic_res_t          res;
    int                mismatches = 0;
    int                n_tests    = 0;

    always #12.5 clk_sys_in = ~clk_sys_in;

    oic_line_model lines_u (.clk_in(clk_sys_in), .line_in(ln), .level_in(lvl), .dig_out(din));
    oic_counter dut_u (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .dig_in(din), .cfg_edit_in(cfg),
        .cfg_commit_in(commit), .cfg_abandon_in(abandon), .cfg_active_out(act), .cfg_reject_out(rej),
        .online_out(onl), .out_lines_out(ol), .res_out(res));

    // ==========================================
    // Shared steps
    task report_and_stop;
        $display("comparisons %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk_sys_in);
    endtask
    // Waits until a base (or extended) interval result is showing, bounded
    task wait_v(input bit ext);
        int k;
        for (k = 0; k < 200; k++)
        begin
            if (ext ? res.ext1_valid === 1'b1 : res.base_valid === 1'b1)
                break;
            cyc(1);
        end
        if (k == 200)
            mismatches++;
    endtask
    task go(input logic st, input logic fon, input logic foff, input logic en, input logic [7:0] pat);
        cfg.on_state = st;
        cfg.full_on  = fon;
        cfg.full_off = foff;
        cfg.out_en   = en;
        cfg.out_pat  = pat;
        commit = 1'b1;
        cyc(1);
        commit = 1'b0;
    endtask

    // ==========================================
    // Scenarios
    task t_cfg;
        `CHK("def_full_on", 1'b0, act.full_on)
        `CHK("def_full_off", 1'b0, act.full_off)
        `CHK("def_base", BASE_RST, act.base_cycles)
        cfg = act;
        cfg.on_line = 5'h03;
        cfg.base_cycles = 16'h0006;
        cfg.ext1_bases = 16'h0003;
        cfg.ext2_bases = 16'h0002;
        cfg.base_store = 16'h0011;
        cfg.ext2_store = 16'h0022;
        cfg.report_num = RPT_MAX;
        go(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        `CHK("cfg_applied", cfg, act)
        `CHK("no_reject", 1'b0, rej)
        for (int i = 0; i < 7; i++)
        begin
            cyc(1);
            cfg.report_num = (i % 2) ? 7'h00 : 7'h64;
            go(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
            `CHK("reject", 1'b1, rej)
            `CHK("rpt_kept", RPT_MAX, act.report_num)
        end
        cfg.report_num = 7'h05;
        cyc(1);
        abandon = 1'b1;
        go(1'b1, 1'b0, 1'b1, 1'b0, 8'h00);
        abandon = 1'b0;
        `CHK("abandon", RPT_MAX, act.report_num)
    endtask
    task t_count;
        wait_v(1'b1);
        for (int i = 0; i < 18; i++)
        begin
            lvl = (i == 1) || (i >= 12);
            cyc(1);
        end
        wait_v(1'b1);
        `CHK("ext1_total", 16'h0002, res.ext1_total)
        `CHK("base_bit", 1'b1, res.base_bit)
        `CHK("ext2_valid", 1'b1, res.ext2_valid)
        `CHK("ext2_total", 16'h0001, res.ext2_total)
        lvl = 1'b0;
    endtask
    task t_out;
        go(1'b1, 1'b0, 1'b1, 1'b1, 8'h0f);
        cyc(3);
        wait_v(1'b0);
        lvl = 1'b1;
        cyc(2);
        `CHK("fast_on", 1'b1, onl)
        cyc(1);
        `CHK("out_on", 8'h0f, ol)
        go(1'b1, 1'b0, 1'b1, 1'b1, 8'hf0);
        cyc(2);
        `CHK("out_new", 8'hff, ol)
        wait_v(1'b0);
        lvl = 1'b0;
        cyc(3);
        `CHK("fast_off", 1'b0, onl)
        `CHK("out_old", 8'h0f, ol)
    endtask
    task t_deb_on;
        go(1'b1, 1'b1, 1'b1, 1'b0, 8'h00);
        wait_v(1'b0);
        for (int i = 0; i < 6; i++)
        begin
            lvl = (i < 4);
            cyc(1);
            `CHK("part_on", 1'b0, onl)
        end
        `CHK("part_bit", 1'b0, res.base_bit)
        lvl = 1'b1;
        cyc(3);
        `CHK("mid_on", 1'b0, onl)
        cyc(4);
        `CHK("full_on", 1'b1, onl)
        `CHK("full_bit", 1'b1, res.base_bit)
    endtask
    task t_deb_off;
        lvl = 1'b0;
        go(1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
        cyc(3);
        `CHK("state0_on", 1'b1, onl)
        wait_v(1'b0);
        lvl = 1'b1;
        cyc(3);
        lvl = 1'b0;
        cyc(3);
        `CHK("part_off", 1'b1, onl)
        wait_v(1'b0);
        lvl = 1'b1;
        cyc(3);
        `CHK("mid_off", 1'b1, onl)
        cyc(4);
        `CHK("full_off", 1'b0, onl)
    endtask

    initial
    begin
        repeat (8) @(posedge clk_sys_in);
        @(negedge clk_sys_in);
        sys_rst_in = 1'b0;
        t_cfg();
        t_count();
        t_out();
        t_deb_on();
        t_deb_off();
        report_and_stop();
    end
    // Whole run needs well under a thousand cycles
    initial
    begin
        repeat (3000) @(posedge clk_sys_in);
        mismatches++;
        report_and_stop();
    end
endmodule

`default_nettype wire
